/* File: swomc_top.sv */
// Operation mode, version/status registers and the control memory access engine
// Assumes core_clk is the receive clock; bus pins and fault pins are asynchronous
//
// Operation
// - Mode 00 clears all code and data locations in 256 cycles; serial interfaces stop.
// - Command 70 hex in mode 00 writes data register everywhere and code 0000.
// - Mode 10 does single accesses at the address register within 2.5 cycles.
// - Mode 11 runs interfaces; single access 10 cycles, tristate init 1035 cycles.
// - Mode 01 keeps switching; each access hits every location, takes 2057 cycles.
// - PCM standby 0 floats transmit outputs and drives used tristate controls high.
// - PCM standby 1 sends upstream data or floats per tristate field.
// - Test loop 1 loops transmit to receive, ignores external receive data.
// - Driver type bit chooses tristate 0 or open-drain 1 for interface outputs.
// - Monitor handshake select disables handshake at 0, enables at 1.
// - Interface standby 0 floats data, data clock and frame sync outputs.
// - Bank select is ORed with upper address line in demultiplexed mode.
// - Version register raises no interrupt; reads change nothing; field access types fixed.
// - Init request sets on clock or power fault, clears on clear command.
// - Writing soft reset bit asserts reset output until the next unit interrupt.
// - Low four bits of version register show a read-only chip version.
// - Monitor channel search stops when found or lower mode bit cleared.
`timescale 1ns/1ps
`include "swomc_defines.svh"
module swomc_top #(
   // Arbitrary revision value
   parameter logic [3:0] CHIP_VERSION = 4'h5
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Parallel processor bus pins
   input  wire logic       bus_mux_mode,
   input  wire logic [5:0] bus_addr,
   input  wire logic       bus_cs_n,
   input  wire logic       bus_rd_n,
   input  wire logic       bus_wr_n,
   input  wire logic [7:0] bus_data_in,
   output logic      [7:0] bus_data_out,
   output logic            bus_data_oe_n,
   // Memory access command from the command register
   input  wire logic       mac_valid,
   input  wire logic [7:0] memory_access_command,
   input  wire logic [7:0] memory_data_register,
   input  wire logic [7:0] memory_address_register,
   output logic            mac_busy,
   // Fault detectors and unit interrupt
   input  wire logic       clock_fault_pin,
   input  wire logic       power_fail_pin,
   input  wire logic       unit_interrupt,
   output logic            external_reset_output,
   // PCM interface
   input  wire logic [3:0] upstream_tx_data,
   input  wire logic [3:0] upstream_tx_float,
   input  wire logic [3:0] tsc_in_use,
   input  wire logic [3:0] tsc_from_switch,
   input  wire logic [3:0] pcm_rx_pin,
   output logic      [3:0] pcm_tx_out,
   output logic      [3:0] pcm_tx_oe_n,
   output logic      [3:0] tristate_control_pins,
   output logic      [3:0] pcm_rx_data,
   // Configurable interface
   input  wire logic [3:0] cfi_dd_data,
   input  wire logic [3:0] cfi_du_data,
   input  wire logic       cfi_dcl_data,
   input  wire logic       cfi_fsc_data,
   input  wire logic [3:0] cfi_du_tx_en,
   output logic      [3:0] downstream_data_outputs,
   output logic      [3:0] downstream_oe_n,
   output logic      [3:0] upstream_data_outputs,
   output logic      [3:0] upstream_oe_n,
   output logic            interface_data_clock,
   output logic            interface_data_clock_oe_n,
   output logic            frame_sync_output,
   output logic            frame_sync_oe_n,
   // Mode controls to the switching core
   output logic            serial_enable,
   output logic            monitor_handshake_en,
   // Monitor channel search
   input  wire logic       mf_search_start,
   input  wire logic       mf_channel_found,
   output logic            mf_search_active
);
   logic [7:0]  opmode_q;
   logic        ir_q;
   logic        external_reset_output_q;
   logic        search_q;
   logic [5:0]  addr_m_q, addr_s_q;
   logic [7:0]  din_m_q, din_s_q;
   logic [2:0]  strb_m_q, strb_s_q, strb_p_q;
   logic [1:0]  flt_m_q, flt_s_q;
   logic        mux_m_q, mux_s_q;
   logic [3:0]  rx_m_q, rx_s_q;
   logic [7:0]  rdata_q;
   logic        cs_s, rd_s, wr_s, wr_end;
   logic [4:0]  reg_addr;
   logic        hit_opmode, hit_version;
   swomc_pkg::swomc_mode_type mode;
   swomc_pkg::swomc_eng_type  eng_q;
   logic [11:0] cnt_q, dur_q;
   logic [8:0]  wptr_q;
   logic [3:0]  code_q;
   logic [7:0]  data_q;
   logic        wr_code_q, wr_data_q;
   logic        clear_cmd;
   logic        running;

   swomc_cm_if cm_bus ();

   function automatic logic drive_n(input logic en, input logic od, input logic val);
      // Open drain only pulls low; tristate drives both levels
      drive_n = !(en && (!od || !val));
   endfunction

   // Two-flop synchronisers for every pin input
   always_ff @(posedge core_clk) begin
      addr_m_q <= bus_addr;
      addr_s_q <= addr_m_q;
      din_m_q  <= bus_data_in;
      din_s_q  <= din_m_q;
      strb_m_q <= {bus_cs_n, bus_rd_n, bus_wr_n};
      strb_s_q <= strb_m_q;
      strb_p_q <= strb_s_q;
      flt_m_q  <= {clock_fault_pin, power_fail_pin};
      flt_s_q  <= flt_m_q;
      rx_m_q   <= pcm_rx_pin;
      rx_s_q   <= rx_m_q;
      mux_m_q  <= bus_mux_mode;
      mux_s_q  <= mux_m_q;
   end

   assign cs_s   = !strb_s_q[2];
   assign rd_s   = cs_s && !strb_s_q[1];
   assign wr_s   = cs_s && !strb_s_q[0];
   // Write commits as the strobe ends, when address and data are settled
   assign wr_end = !strb_p_q[2] && !strb_p_q[0] && !wr_s;

   // Multiplexed address is shifted up; opmode answers in both banks there, in bank 0 only when demultiplexed
   always_comb begin
      if (mux_s_q) begin
         reg_addr = {addr_s_q[5] & ~&addr_s_q[4:1], addr_s_q[4:1]};
      end else begin
         reg_addr = {addr_s_q[4] | opmode_q[`SWOMC_OM_RBS], addr_s_q[3:0]};
      end
   end

   assign hit_opmode  = (reg_addr == `SWOMC_OFS_OPMODE);
   assign hit_version = (reg_addr == `SWOMC_OFS_VERSION);

   // Operation mode register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         opmode_q <= `SWOMC_OPMODE_RESET;
      end else if (wr_end && hit_opmode) begin
         opmode_q <= din_s_q;
      end
   end

   assign mode = swomc_pkg::swomc_mode_type'(opmode_q[`SWOMC_OM_MODE_HI:`SWOMC_OM_MODE_LO]);

   // Read data; no register changes on a read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_q <= 8'h00;
      end else if (rd_s) begin
         if (hit_opmode) begin
            rdata_q <= opmode_q;
         end else if (hit_version) begin
            rdata_q <= {ir_q, 3'h0, CHIP_VERSION};
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign bus_data_out  = rdata_q;
   assign bus_data_oe_n = !rd_s;

   // Initialization request: fault setting wins over the clear command
   assign clear_cmd = (eng_q == swomc_pkg::SWOMC_ENG_IDLE) && mac_valid
                      && (mode == swomc_pkg::SWOMC_MODE_CM_RESET)
                      && (memory_access_command[7:4] == `SWOMC_CMD_CLEAR_ALL);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ir_q <= 1'b0;
      end else if (|flt_s_q) begin
         ir_q <= 1'b1;
      end else if (clear_cmd) begin
         ir_q <= 1'b0;
      end
   end

   // External reset output; the unit interrupt ends it, a fresh write wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         external_reset_output_q <= 1'b0;
      end else if (wr_end && hit_version && din_s_q[`SWOMC_VS_EXTERNAL_SOFT_RESET_BIT]) begin
         external_reset_output_q <= 1'b1;
      end else if (unit_interrupt) begin
         external_reset_output_q <= 1'b0;
      end
   end

   assign external_reset_output = external_reset_output_q;

   // Monitor channel search
   always_ff @(posedge core_clk) begin
      if (reset) begin
         search_q <= 1'b0;
      end else if (mf_channel_found || !opmode_q[`SWOMC_OM_MODE_LO]) begin
         search_q <= 1'b0;
      end else if (mf_search_start) begin
         search_q <= 1'b1;
      end
   end

   assign mf_search_active     = search_q;
   assign monitor_handshake_en = opmode_q[`SWOMC_OM_MONITOR_HANDSHAKE_SELECT];

   // Control memory access engine
   always_ff @(posedge core_clk) begin
      if (reset) begin
         eng_q     <= swomc_pkg::SWOMC_ENG_IDLE;
         cnt_q     <= 12'd0;
         dur_q     <= 12'd0;
         wptr_q    <= 9'd0;
         code_q    <= 4'h0;
         data_q    <= 8'h00;
         wr_code_q <= 1'b0;
         wr_data_q <= 1'b0;
      end else begin
         unique case (eng_q)
            swomc_pkg::SWOMC_ENG_IDLE: begin
               cnt_q  <= 12'd1;
               code_q <= memory_access_command[3:0];
               data_q <= memory_data_register;
               if (mac_valid) begin
                  unique case (mode)
                     swomc_pkg::SWOMC_MODE_CM_RESET: begin
                        if (clear_cmd) begin
                           eng_q     <= swomc_pkg::SWOMC_ENG_ALL;
                           dur_q     <= `SWOMC_CYC_RESET_ALL;
                           wptr_q    <= 9'd0;
                           code_q    <= `SWOMC_CODE_UNASSIGN;
                           wr_code_q <= 1'b1;
                           wr_data_q <= 1'b1;
                        end
                     end
                     swomc_pkg::SWOMC_MODE_CM_INIT: begin
                        eng_q     <= swomc_pkg::SWOMC_ENG_ONE;
                        dur_q     <= `SWOMC_CYC_INIT;
                        wptr_q    <= {1'b0, memory_address_register};
                        wr_code_q <= 1'b1;
                        wr_data_q <= 1'b1;
                     end
                     swomc_pkg::SWOMC_MODE_NORMAL: begin
                        wptr_q <= {1'b0, memory_address_register};
                        if (memory_access_command[7:4] == `SWOMC_CMD_TS_INIT) begin
                           eng_q     <= swomc_pkg::SWOMC_ENG_ALL;
                           dur_q     <= `SWOMC_CYC_TS_INIT;
                           wptr_q    <= 9'd0;
                           wr_code_q <= 1'b1;
                           wr_data_q <= 1'b0;
                        end else begin
                           eng_q     <= swomc_pkg::SWOMC_ENG_ONE;
                           dur_q     <= `SWOMC_CYC_NORMAL;
                           wr_code_q <= 1'b1;
                           wr_data_q <= 1'b1;
                        end
                     end
                     swomc_pkg::SWOMC_MODE_TEST: begin
                        eng_q     <= swomc_pkg::SWOMC_ENG_ALL;
                        dur_q     <= `SWOMC_CYC_TEST;
                        wptr_q    <= 9'd0;
                        wr_code_q <= 1'b1;
                        wr_data_q <= 1'b1;
                     end
                  endcase
               end
            end
            swomc_pkg::SWOMC_ENG_ALL: begin
               // Every location written once, then the rest of the time is idle wait
               if (!wptr_q[8]) begin
                  wptr_q <= wptr_q + 9'd1;
               end
               cnt_q <= cnt_q + 12'd1;
               if (cnt_q >= dur_q) begin
                  eng_q <= swomc_pkg::SWOMC_ENG_IDLE;
               end
            end
            swomc_pkg::SWOMC_ENG_ONE: begin
               wptr_q[8] <= 1'b1;
               cnt_q     <= cnt_q + 12'd1;
               if (cnt_q >= dur_q) begin
                  eng_q <= swomc_pkg::SWOMC_ENG_IDLE;
               end
            end
         endcase
      end
   end

   assign running         = (eng_q != swomc_pkg::SWOMC_ENG_IDLE);
   assign mac_busy        = running;
   assign cm_bus.we       = running && !wptr_q[8];
   assign cm_bus.we_code  = wr_code_q;
   assign cm_bus.we_data  = wr_data_q;
   assign cm_bus.addr     = wptr_q[7:0];
   assign cm_bus.wcode    = code_q;
   assign cm_bus.wdata    = data_q;

   swomc_cm_mem u_cm (
      .core_clk (core_clk),
      .cm       (cm_bus)
   );

   // Serial interfaces run only in normal and test modes
   assign serial_enable = opmode_q[`SWOMC_OM_MODE_LO];

   // PCM pins; the loop takes the transmit value even where the pin floats
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pcm_tx_out[i]  = upstream_tx_data[i];
         pcm_tx_oe_n[i] = !(serial_enable && opmode_q[`SWOMC_OM_PSB] && !upstream_tx_float[i]);
         tristate_control_pins[i] = (!opmode_q[`SWOMC_OM_PSB] && tsc_in_use[i])
                                    ? 1'b1 : tsc_from_switch[i];
         pcm_rx_data[i] = opmode_q[`SWOMC_OM_PTL] ? upstream_tx_data[i] : rx_s_q[i];
      end
   end

   // Configurable interface pins
   always_comb begin
      logic en;
      logic od;
      en = serial_enable && opmode_q[`SWOMC_OM_CSB];
      od = opmode_q[`SWOMC_OM_COS];
      for (int i = 0; i < 4; i++) begin
         downstream_data_outputs[i] = cfi_dd_data[i];
         upstream_data_outputs[i]   = cfi_du_data[i];
         downstream_oe_n[i] = drive_n(en, od, cfi_dd_data[i]);
         upstream_oe_n[i]   = drive_n(en && cfi_du_tx_en[i], od, cfi_du_data[i]);
      end
      interface_data_clock      = cfi_dcl_data;
      interface_data_clock_oe_n = drive_n(en, od, cfi_dcl_data);
      frame_sync_output         = cfi_fsc_data;
      frame_sync_oe_n           = drive_n(en, od, cfi_fsc_data);
   end
endmodule // swomc_top

/* File: swomc_defines.svh */
// Offsets, field positions, reset values and cycle counts of the mode control
// Assumes inclusion by both design modules and the package users
`ifndef SWOMC_DEFINES_SVH
`define SWOMC_DEFINES_SVH

// Register offsets (demultiplexed address, 5 bits)
`define SWOMC_OFS_OPMODE     5'h0f
`define SWOMC_OFS_VERSION    5'h1d
`define SWOMC_OPMODE_RESET   8'h00

// Operation mode field positions
`define SWOMC_OM_MODE_HI     7
`define SWOMC_OM_MODE_LO     6
`define SWOMC_OM_PSB         5
`define SWOMC_OM_PTL         4
`define SWOMC_OM_COS         3
`define SWOMC_OM_MONITOR_HANDSHAKE_SELECT        2
`define SWOMC_OM_CSB         1
`define SWOMC_OM_RBS         0

// Version and status field positions
`define SWOMC_VS_IR          7
`define SWOMC_VS_EXTERNAL_SOFT_RESET_BIT        4

// Memory access command codes
`define SWOMC_CMD_CLEAR_ALL  4'h7
`define SWOMC_CMD_TS_INIT    4'h6
`define SWOMC_CODE_UNASSIGN  4'h0

// Control memory geometry
`define SWOMC_CM_AW          8
`define SWOMC_CM_DEPTH       256

// Access durations in receive clock cycles
`define SWOMC_CYC_RESET_ALL  12'd256
`define SWOMC_CYC_INIT_MAX_X2 12'd5
`define SWOMC_CYC_INIT       (`SWOMC_CYC_INIT_MAX_X2 / 12'd2)
`define SWOMC_CYC_NORM_X2    12'd19
`define SWOMC_CYC_NORMAL     ((`SWOMC_CYC_NORM_X2 + 12'd1) / 12'd2)
`define SWOMC_CYC_TS_INIT    12'd1035
`define SWOMC_CYC_TEST       12'd2057

`endif

/* File: swomc_pkg.sv */
// Types of the mode control: operation modes and access engine states
// Assumes swomc_defines.svh is on the include path
package swomc_pkg;
   typedef enum logic [1:0] {
      SWOMC_MODE_CM_RESET = 2'h0,
      SWOMC_MODE_TEST     = 2'h1,
      SWOMC_MODE_CM_INIT  = 2'h2,
      SWOMC_MODE_NORMAL   = 2'h3
   } swomc_mode_type;

   typedef enum logic [1:0] {
      SWOMC_ENG_IDLE,
      SWOMC_ENG_ALL,
      SWOMC_ENG_ONE
   } swomc_eng_type;
endpackage

/* File: swomc_cm_if.sv */
// Write and read path between the mode control and its control memory
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface swomc_cm_if;
   logic        we;
   logic        we_code;
   logic        we_data;
   logic [7:0]  addr;
   logic [3:0]  wcode;
   logic [7:0]  wdata;
   logic [11:0] rdata;

   modport ctl (output we, output we_code, output we_data, output addr,
                output wcode, output wdata, input rdata);
   modport mem (input we, input we_code, input we_data, input addr,
                input wcode, input wdata, output rdata);
endinterface

/* File: swomc_cm_mem.sv */
// Control memory: 4-bit code field and 8-bit data field per location
// Assumes the controller writes one location per clock at most
`timescale 1ns/1ps
`include "swomc_defines.svh"
module swomc_cm_mem (
   // Clock
   input wire logic core_clk,
   // Access port
   swomc_cm_if.mem  cm
);
   logic [3:0]  code_mem [`SWOMC_CM_DEPTH];
   logic [7:0]  data_mem [`SWOMC_CM_DEPTH];
   logic [11:0] rdata_q;

   // No reset on the array; contents are undefined until a clear command
   always_ff @(posedge core_clk) begin
      if (cm.we && cm.we_code) begin
         code_mem[cm.addr] <= cm.wcode;
      end
      if (cm.we && cm.we_data) begin
         data_mem[cm.addr] <= cm.wdata;
      end
      rdata_q <= {code_mem[cm.addr], data_mem[cm.addr]};
   end

   assign cm.rdata = rdata_q;
endmodule // swomc_cm_mem

/* File: swomc_top_sva.sv */
// Concurrent checks on the mode control ports
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module swomc_top_sva (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // Bus and command
   input wire logic       bus_cs_n,
   input wire logic       bus_rd_n,
   input wire logic       bus_wr_n,
   input wire logic       bus_data_oe_n,
   input wire logic       mac_valid,
   input wire logic       mac_busy,
   // Reset output
   input wire logic       unit_interrupt,
   input wire logic       external_reset_output,
   // Serial outputs and search
   input wire logic [3:0] pcm_tx_oe_n,
   input wire logic [3:0] downstream_oe_n,
   input wire logic [3:0] upstream_oe_n,
   input wire logic       frame_sync_oe_n,
   input wire logic       serial_enable,
   input wire logic       mf_search_start,
   input wire logic       mf_channel_found,
   input wire logic       mf_search_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Busy run length, beyond any repetition count
   logic [11:0] busy_cnt_q;
   always_ff @(posedge core_clk) begin
      if (reset || !mac_busy) begin
         busy_cnt_q <= 12'h000;
      end else begin
         busy_cnt_q <= busy_cnt_q + 12'h001;
      end
   end
   serial_off_a: assert property (!serial_enable |-> pcm_tx_oe_n == 4'hf && downstream_oe_n == 4'hf
      && upstream_oe_n == 4'hf && frame_sync_oe_n) else $error("outputs driven while stopped");
   busy_cause_a: assert property ($rose(mac_busy) |-> $past(mac_valid))
      else $error("busy without a command");
   busy_min_a: assert property ($rose(mac_busy) |-> mac_busy [*2]) else $error("busy too short");
   busy_len_a: assert property ($fell(mac_busy) |-> busy_cnt_q inside {12'd2, 12'd10, 12'd256,
      12'd1035, 12'd2057}) else $error("bad busy length");
   xrst_clear_a: assert property ($fell(external_reset_output) |-> $past(unit_interrupt) || $past(reset))
      else $error("reset output fell early");
   xrst_set_a: assert property ($rose(external_reset_output) |-> !$past(bus_wr_n, 4))
      else $error("reset output rose without a write");
   rd_oe_a: assert property (!bus_data_oe_n |-> $past(bus_rd_n, 2) == 1'b0 && $past(bus_cs_n, 2) == 1'b0)
      else $error("data bus driven without read");
   search_off_a: assert property (!serial_enable |=> !mf_search_active)
      else $error("search runs in stopped mode");
   search_found_a: assert property (mf_channel_found && !mf_search_start |=> !mf_search_active)
      else $error("search runs after channel found");
   long_busy_c: cover property ($fell(mac_busy) && busy_cnt_q == 12'd2057);
   xrst_c: cover property ($rose(external_reset_output));
   search_c: cover property ($rose(mf_search_active));
endmodule // swomc_top_sva
bind swomc_top swomc_top_sva u_sva (.core_clk, .reset, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_oe_n,
   .mac_valid, .mac_busy, .unit_interrupt, .external_reset_output, .pcm_tx_oe_n, .downstream_oe_n,
   .upstream_oe_n, .frame_sync_oe_n, .serial_enable, .mf_search_start, .mf_channel_found, .mf_search_active);

/* File: swomc_host_model.sv */
// Host processor model driving the parallel register bus
// Assumes the device samples the pins through two-flop synchronisers
`timescale 1ns/1ps
module swomc_host_model (
   // Clock
   input wire logic       core_clk,
   // Bus pins
   output logic           bus_mux_mode,
   output logic     [5:0] bus_addr,
   output logic           bus_cs_n,
   output logic           bus_rd_n,
   output logic           bus_wr_n,
   output logic     [7:0] bus_data_in,
   input wire logic [7:0] bus_data_out
);
   initial begin
      {bus_mux_mode, bus_addr, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_in} = 18'h00700;
   end
   // Write strobes held four cycles each side, read strobes five low and four high; the synced copy lags two
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_data_in <= d;
      {bus_cs_n, bus_wr_n} <= 2'h0;
      repeat (4) @(posedge core_clk);
      {bus_cs_n, bus_wr_n} <= 2'h3;
      repeat (4) @(posedge core_clk);
      bus_data_in <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      {bus_cs_n, bus_rd_n} <= 2'h0;
      repeat (5) @(posedge core_clk);
      d = bus_data_out;
      {bus_cs_n, bus_rd_n} <= 2'h3;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic mux(input logic m);
      @(posedge core_clk);
      bus_mux_mode <= m;
   endtask
endmodule // swomc_host_model

/* File: tb.sv */
// Self-checking bench for the mode control with a host bus model
// Assumes the package, interface, memory and top are compiled first
`timescale 1ns/1ps
module tb;
   logic        core_clk, reset, mac_valid, clock_fault_pin, power_fail_pin, unit_interrupt, mac_busy;
   logic        cfi_dcl_data, cfi_fsc_data, mf_search_start, mf_channel_found, mf_search_active;
   logic        bus_mux_mode, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe_n, external_reset_output;
   logic        interface_data_clock, interface_data_clock_oe_n, frame_sync_output, frame_sync_oe_n;
   logic        serial_enable, monitor_handshake_en;
   logic [5:0]  bus_addr;
   logic [7:0]  bus_data_in, bus_data_out, memory_access_command, memory_data_register, memory_address_register;
   logic [3:0]  upstream_tx_data, upstream_tx_float, tsc_in_use, tsc_from_switch, pcm_rx_pin, pcm_tx_out;
   logic [3:0]  pcm_tx_oe_n, tristate_control_pins, pcm_rx_data, cfi_dd_data, cfi_du_data, cfi_du_tx_en;
   logic [3:0]  downstream_data_outputs, downstream_oe_n, upstream_data_outputs, upstream_oe_n;
   logic [31:0] seed;
   logic [7:0]  rv, om, c;
   logic [11:0] dur;
   int          mismatches, n_checks;
   localparam logic [3:0] VER = 4'ha; // Arbitrary revision value
   swomc_host_model host (.*);
   swomc_top #(.CHIP_VERSION(VER)) DUT (.*);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [11:0] exp_dur(input logic [1:0] m, input logic [7:0] k);
      case (m)
         2'h0: return 12'd256;
         2'h2: return 12'd2;
         2'h3: return (k[7:4] == 4'h6) ? 12'd1035 : 12'd10;
         default: return 12'd2057;
      endcase
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
      host.rd(a, rv);
      chk(nm, {4'h0, e}, {4'h0, rv});
   endtask
   task automatic cmd(input logic [7:0] k);
      int n;
      n = 0;
      @(posedge core_clk);
      memory_access_command <= k;
      memory_data_register <= 8'(rnd());
      memory_address_register <= 8'(rnd());
      mac_valid <= 1'b1;
      @(posedge core_clk);
      mac_valid <= 1'b0;
      #1;
      while (mac_busy === 1'b1 && n < 3000) begin
         n++;
         @(posedge core_clk);
         mac_valid <= (n == 1);
         #1;
      end
      if (n >= 3000) begin
         mismatches++;
         tally_and_finish();
      end
      dur = 12'(n);
   endtask
   task automatic pins();
      @(posedge core_clk);
      {upstream_tx_data, upstream_tx_float, tsc_in_use, tsc_from_switch, pcm_rx_pin} <= 20'(rnd());
      {cfi_dd_data, cfi_du_data, cfi_du_tx_en, cfi_dcl_data, cfi_fsc_data} <= 14'(rnd());
   endtask
   task automatic check_pins(input logic [7:0] m);
      logic       sp, sc;
      logic [3:0] oe, uo;
      logic [11:0] e;
      #1;
      sp = m[6] & m[5];
      sc = m[6] & m[1];
      oe = sp ? upstream_tx_float : 4'hf;
      uo = m[3] ? (~cfi_du_tx_en | cfi_du_data) : ~cfi_du_tx_en;
      e = sc ? {2'h0, m[3] ? cfi_dd_data : 4'h0, uo, m[3] & cfi_dcl_data, m[3] & cfi_fsc_data} : 12'h3ff;
      chk("pcm_oe", {8'h0, oe}, {8'h0, pcm_tx_oe_n});
      chk("pcm_tx", {8'h0, upstream_tx_data & ~oe}, {8'h0, pcm_tx_out & ~oe});
      if (!m[5]) chk("tsc", {8'h0, tsc_in_use}, {8'h0, tristate_control_pins & tsc_in_use});
      if (m[6]) chk("rx", {8'h0, m[4] ? upstream_tx_data : pcm_rx_pin}, {8'h0, pcm_rx_data});
      chk("cfi_oe", e, {2'h0, downstream_oe_n, upstream_oe_n, interface_data_clock_oe_n, frame_sync_oe_n});
      chk("cfi_dat", {2'h0, cfi_dd_data, cfi_du_data, cfi_dcl_data, cfi_fsc_data},
         {2'h0, downstream_data_outputs, upstream_data_outputs, interface_data_clock, frame_sync_output});
      chk("mode_bits", {10'h0, m[6], m[2]}, {10'h0, serial_enable, monitor_handshake_en});
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      {reset, mac_valid, clock_fault_pin, power_fail_pin, unit_interrupt, mf_search_start} = 6'h20;
      {mf_channel_found, memory_access_command, memory_data_register, memory_address_register} = 25'h0;
      {upstream_tx_data, upstream_tx_float, tsc_in_use, tsc_from_switch, pcm_rx_pin} = 20'h0;
      {cfi_dd_data, cfi_du_data, cfi_du_tx_en, cfi_dcl_data, cfi_fsc_data} = 14'h0;
      seed = 32'hbe34735b;
      mismatches = 0;
      n_checks = 0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rdchk("opmode_rst", 6'h0f, 8'h00);
      rdchk("version", 6'h1d, {4'h0, VER});
      rdchk("version_again", 6'h1d, {4'h0, VER});
      rdchk("unmapped", 6'h05, 8'h00);
      cmd(8'h50);
      chk("refused", 12'd0, dur);
      cmd(8'h70);
      chk("clear_len", 12'd256, dur);
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         {clock_fault_pin, power_fail_pin} <= (i == 0) ? 2'h2 : 2'h1;
         repeat (4) @(posedge core_clk);
         {clock_fault_pin, power_fail_pin} <= 2'h0;
         rdchk("ir_set", 6'h1d, {4'h8, VER});
         cmd({4'h7, 4'(rnd())});
         rdchk("ir_clear", 6'h1d, {4'h0, VER});
      end
      for (int k = 0; k < 8; k++) begin
         om = {2'(k), 6'(rnd()) & 6'h3e};
         host.wr(6'h0f, om);
         pins();
         rdchk("opmode", 6'h0f, om);
         check_pins(om);
         c = 8'(rnd());
         if (om[7:6] == 2'h0) c[7:4] = 4'h7;
         if (om[7:6] == 2'h3 && k < 4) c[7:4] = 4'h6;
         cmd(c);
         chk("busy_len", exp_dur(om[7:6], c), dur);
      end
      host.mux(1'b1);
      host.wr(6'h1e, 8'hc0);
      rdchk("mux_opmode", 6'h3e, 8'hc0);
      rdchk("mux_version", 6'h3a, {4'h0, VER});
      host.mux(1'b0);
      host.wr(6'h1d, 8'hef);
      rdchk("ro_bits", 6'h1d, {4'h0, VER});
      host.wr(6'h1d, 8'h10);
      chk("xrst_on", 12'h1, {11'h0, external_reset_output});
      @(posedge core_clk);
      unit_interrupt <= 1'b1;
      @(posedge core_clk);
      unit_interrupt <= 1'b0;
      #1;
      chk("xrst_off", 12'h0, {11'h0, external_reset_output});
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         mf_search_start <= 1'b1;
         @(posedge core_clk);
         mf_search_start <= 1'b0;
         #1;
         chk("search_on", 12'h1, {11'h0, mf_search_active});
         if (i == 0) begin
            @(posedge core_clk);
            mf_channel_found <= 1'b1;
            @(posedge core_clk);
            mf_channel_found <= 1'b0;
         end else host.wr(6'h0f, 8'h80);
         #1;
         chk("search_off", 12'h0, {11'h0, mf_search_active});
      end
      host.wr(6'h0f, 8'h01);
      rdchk("bank_sel", 6'h0f, 8'h00);
      rdchk("bank_ver", 6'h1d, {4'h0, VER});
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rdchk("opmode_rst2", 6'h0f, 8'h00);
      cmd(8'h70);
      chk("clear_len2", 12'd256, dur);
      tally_and_finish();
   end
endmodule // tb
